// [hw/aorc_pkg.sv]
// constants and enumerations of the converter output-read and control block
package aorc_pkg;

    localparam int unsigned RES_W         = 12;
    localparam int unsigned HIGH_BYTE_LSB = 4;
    localparam int unsigned NIB_W         = 4;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;

    // clock and timing, times in ns as specified
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned HOLD_MIN_NS     = 300;
    localparam int unsigned HOLD_MAX_NS     = 1000;
    localparam int unsigned HOLD_MIN_CYC    = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_MAX_CYC    = HOLD_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC        = HOLD_MIN_CYC;
    localparam int unsigned BIT_CYC_DEFAULT = 4;
    localparam int unsigned TICK_W          = 6;
    localparam int unsigned BIT_IDX_W       = 4;

    // conversion lengths as index of the last bit decided
    localparam logic [3:0] MSB_IDX      = 4'hB;
    localparam logic [3:0] LAST_IDX_12  = 4'h0;
    localparam logic [3:0] LAST_IDX_8   = 4'h4;
    // low nibble returned after a short conversion: bit 3 high, three lsbs low
    localparam logic [3:0] SHORT_FILL   = 4'h8;

    // output enable patterns, low means driven
    localparam logic [11:0] OE_N_OFF   = 12'hFFF;
    localparam logic [11:0] OE_N_WORD  = 12'h000;
    localparam logic [11:0] OE_N_HIGH  = 12'h00F;
    localparam logic [11:0] OE_N_LOW   = 12'hF00;

    // register map, byte addresses
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS   = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS   = 8'h0C;

    // status and mask fields
    localparam int unsigned EV_W         = 2;
    localparam int unsigned EV_DONE      = 0;
    localparam int unsigned EV_IGNORED   = 1;
    localparam logic [1:0]  STATUS_RST   = 2'h0;
    localparam logic [1:0]  MASK_RST     = 2'h0;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CONVERT,
        PH_HOLD
    } aorc_phase_e;

    typedef enum logic [1:0] {
        DRV_OFF,
        DRV_WORD,
        DRV_HIGH,
        DRV_LOW
    } aorc_drive_e;

endpackage : aorc_pkg

// [hw/aorc_sync.sv]
// two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/10ps
module aorc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    input  wire logic [WIDTH-1:0] ASYNC_IN,
    output logic      [WIDTH-1:0] SYNC_OUT
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } aorc_sync_s;

    aorc_sync_s state_reg;
    aorc_sync_s state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = ASYNC_IN;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign SYNC_OUT = state_reg.stage2;

endmodule : aorc_sync

// [hw/aorc_top.sv]
// converter conversion sequencing, tri-state output read gating and status registers
//
// Contract
// R1 - outputs float unless all four read conditions hold
// R2 - word mode drives all twelve, ignores byte_select
// R3 - byte mode: two left-justified bytes, byte_select picks
// R4 - byte_select low: only eight msbs enabled
// R5 - byte_select high: four lsbs, bits 4-7 zero
// R6 - byte_select may toggle any time safely
// R7 - break before make between the two bytes
// R8 - host reads after busy falls, or bounded earlier
// R9 - result valid 300 to 1000 ns before busy falls
// R10 - host holds read_convert low 50 ns with enable
// R11 - host holds select low 50 ns with enable
// R12 - stand-alone low read_convert pulse at least 50 ns
// R13 - stand-alone high read_convert pulse at least 150 ns
// R14 - last of three start conditions starts conversion
// R15 - busy only while converting; starts ignored, outputs float
// R16 - byte_select latched at start sets conversion length; the code also relatches it on a start refused while converting
// R17 - short conversion reads lsbs zero, bit 3 one
// R18 - outputs float once any read condition drops
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module aorc_top #(
    parameter int unsigned BIT_CYC = aorc_pkg::BIT_CYC_DEFAULT
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // control pins, asynchronous to CLK
    input  wire logic        READ_CONVERT,
    input  wire logic        CHIP_ENABLE,
    input  wire logic        CHIP_SELECT_N,
    input  wire logic        BYTE_SELECT,
    input  wire logic        WORD_WIDTH_SELECT,
    // comparator from the analog front end, high when input is above the trial code
    input  wire logic        COMP_IN,
    output logic      [11:0] DAC_CODE,
    // data pins as output value and active-low enable per bit
    output logic      [11:0] DATA_OUT,
    output logic      [11:0] DATA_OE_N,
    output logic             CONV_BUSY,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic             IRQ
);

    // all state of the block except the pin synchroniser flops lives in one record, registered as a whole
    // phase and tick sequence the conversion and the hold before busy drops
    // bit_idx points at the trial bit being decided, msb first
    // trial drives the comparator reference, result holds the last finished code
    // data and oe_n are the registered pin images, low enable means driven
    // drive remembers the pattern shown last, for break before make
    // start_prev finds the moment the start condition comes true
    // status, mask and irq form the event block, rdata the bus answer
    typedef struct packed {
        aorc_pkg::aorc_phase_e phase;
        aorc_pkg::aorc_drive_e drive;
        logic                  eight_bit;
        logic [3:0]            bit_idx;
        logic [5:0]            tick;
        logic [11:0]           trial;
        logic [11:0]           result;
        logic [11:0]           data;
        logic [11:0]           oe_n;
        logic                  busy;
        logic                  start_prev;
        logic [1:0]            status;
        logic [1:0]            mask;
        logic [31:0]           rdata;
        logic                  irq;
    } aorc_state_s;

    aorc_state_s state_reg;
    aorc_state_s state_next;

    // every control pin and the comparator are asynchronous to CLK, so all of
    // them pass the same two flops; a pin change is seen two edges later
    logic [5:0] pins_sync;
    logic       rc_s;
    logic       ce_s;
    logic       cs_n_s;
    logic       bsel_s;
    logic       wsel_s;
    logic       comp_s;

    aorc_sync #(
        .WIDTH (6)
    ) u_sync (
        .CLK      (CLK),
        .SYS_RST  (SYS_RST),
        .ASYNC_IN ({COMP_IN, WORD_WIDTH_SELECT, BYTE_SELECT,
                    CHIP_SELECT_N, CHIP_ENABLE, READ_CONVERT}),
        .SYNC_OUT (pins_sync)
    );

    assign rc_s   = pins_sync[0];
    assign ce_s   = pins_sync[1];
    assign cs_n_s = pins_sync[2];
    assign bsel_s = pins_sync[3];
    assign wsel_s = pins_sync[4];
    assign comp_s = pins_sync[5];

    localparam logic [5:0] BIT_LAST  = 6'(BIT_CYC - 1);
    localparam logic [5:0] HOLD_LAST = 6'(aorc_pkg::HOLD_CYC - 1);

    logic                  start_cond;
    logic                  start_edge;
    logic                  read_en;
    logic                  wr_status;
    logic                  wr_mask;
    logic [1:0]            events;
    logic [3:0]            last_idx;
    logic [11:0]           kept;
    aorc_pkg::aorc_drive_e want;

    always_comb begin
        state_next = state_reg;
        events     = 2'h0;
        kept       = state_reg.trial;
        want       = aorc_pkg::DRV_OFF;

        // start request is the moment the last of the three conditions comes true
        start_cond = ce_s & ~cs_n_s & ~rc_s;                                    // R14
        start_edge = start_cond & ~state_reg.start_prev;                        // R14
        state_next.start_prev = start_cond;

        // the conversion stops at bit 4 for a short conversion, at bit 0 otherwise
        last_idx = state_reg.eight_bit ? aorc_pkg::LAST_IDX_8 : aorc_pkg::LAST_IDX_12;

        // idle waits for a start edge; convert decides one bit every BIT_CYC
        // cycles; hold keeps busy high a fixed time after the result is latched

        unique case (state_reg.phase)
            aorc_pkg::PH_IDLE: begin
                if (start_edge) begin
                    state_next.phase     = aorc_pkg::PH_CONVERT;
                    state_next.busy      = 1'b1;                                // R15
                    state_next.eight_bit = bsel_s;                              // R16
                    state_next.bit_idx   = aorc_pkg::MSB_IDX;
                    state_next.tick      = 6'h00;
                    state_next.trial     = 12'h800;
                end
            end
            aorc_pkg::PH_CONVERT: begin
                // a restart is refused but still relatches the length choice
                if (start_edge) begin
                    events[aorc_pkg::EV_IGNORED] = 1'b1;                        // R15
                    state_next.eight_bit = bsel_s;                              // R16
                end
                // the comparator lags two edges behind the trial code, so the
                // decision waits for the last tick of the bit
                if (state_reg.tick == BIT_LAST) begin
                    state_next.tick = 6'h00;
                    // keep the trial bit only when the input is above the trial level
                    kept[state_reg.bit_idx] = comp_s;
                    // a late switch to short length may already be past bit 4
                    if (state_reg.bit_idx <= last_idx) begin
                        state_next.trial = kept;
                        if (state_reg.eight_bit) begin
                            state_next.result = {kept[11:4], aorc_pkg::SHORT_FILL}; // R17
                        end else begin
                            state_next.result = kept;
                        end
                        state_next.phase = aorc_pkg::PH_HOLD;                   // R9
                    end else begin
                        state_next.bit_idx = 4'(state_reg.bit_idx - 4'h1);
                        kept[4'(state_reg.bit_idx - 4'h1)] = 1'b1;
                        state_next.trial = kept;
                    end
                end else begin
                    state_next.tick = 6'(state_reg.tick + 6'h01);
                end
            end
            aorc_pkg::PH_HOLD: begin
                if (start_edge) begin
                    events[aorc_pkg::EV_IGNORED] = 1'b1;                        // R15
                end
                // result stands latched a fixed hold before busy drops
                if (state_reg.tick == HOLD_LAST) begin                          // R9
                    state_next.tick  = 6'h00;
                    state_next.phase = aorc_pkg::PH_IDLE;
                    state_next.busy  = 1'b0;                                    // R9
                    events[aorc_pkg::EV_DONE] = 1'b1;
                end else begin
                    state_next.tick = 6'(state_reg.tick + 6'h01);
                end
            end
        endcase

        // read gating on all four conditions, live each cycle; the next busy
        // value is used so the drivers let go on the edge where busy rises
        read_en = rc_s & ~state_next.busy & ce_s & ~cs_n_s;                     // R1 R15 R18
        if (!read_en) begin
            want = aorc_pkg::DRV_OFF;                                           // R1 R18
        end else if (wsel_s) begin
            want = aorc_pkg::DRV_WORD;                                          // R2
        end else if (bsel_s) begin
            want = aorc_pkg::DRV_LOW;                                           // R3 R5
        end else begin
            want = aorc_pkg::DRV_HIGH;                                          // R3 R4
        end

        // any change between two driving patterns passes one all-off cycle
        // so that the shared byte lines are never driven from two sides
        if (state_reg.drive != aorc_pkg::DRV_OFF && want != aorc_pkg::DRV_OFF &&
            want != state_reg.drive) begin
            state_next.drive = aorc_pkg::DRV_OFF;                               // R6 R7
        end else begin
            state_next.drive = want;
        end

        // pin images follow the chosen pattern; data keeps its old value while
        // everything floats, which the pins never show
        unique case (state_next.drive)
            aorc_pkg::DRV_OFF: begin
                state_next.oe_n = aorc_pkg::OE_N_OFF;                           // R1
            end
            aorc_pkg::DRV_WORD: begin
                state_next.oe_n = aorc_pkg::OE_N_WORD;                          // R2
                state_next.data = state_next.result;
            end
            aorc_pkg::DRV_HIGH: begin
                state_next.oe_n = aorc_pkg::OE_N_HIGH;                          // R4
                state_next.data = {state_next.result[11:4], 4'h0};
            end
            aorc_pkg::DRV_LOW: begin
                state_next.oe_n = aorc_pkg::OE_N_LOW;                           // R5
                state_next.data = {4'h0, 4'h0, state_next.result[3:0]};         // R5
            end
        endcase

        // register port: status is write-one-to-clear, a new event wins over the clear
        wr_status = REG_WR && (REG_ADDR == aorc_pkg::STATUS_OFS);
        wr_mask   = REG_WR && (REG_ADDR == aorc_pkg::MASK_OFS);
        if (wr_status) begin
            state_next.status = state_reg.status & ~REG_WDATA[1:0];
        end
        state_next.status = state_next.status | events;
        if (wr_mask) begin
            state_next.mask = REG_WDATA[1:0];
        end

        // read data stand for the one cycle after the strobe and are zero otherwise
        state_next.rdata = 32'h0000_0000;
        if (REG_RD) begin
            unique case (REG_ADDR)
                aorc_pkg::STATUS_OFS: begin
                    state_next.rdata = {30'h0, state_reg.status};
                end
                aorc_pkg::MASK_OFS: begin
                    state_next.rdata = {30'h0, state_reg.mask};
                end
                aorc_pkg::RESULT_OFS: begin
                    state_next.rdata = {20'h0, state_reg.result};
                end
                aorc_pkg::CTRL_OFS: begin
                    state_next.rdata = {28'h0, state_reg.eight_bit, state_reg.busy,
                                        state_reg.drive};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // level interrupt from the next status, so it rises with the event
        state_next.irq = |(state_next.status & state_next.mask);
    end

    // start_prev resets high, but the synchronised pins read low for two cycles after release, so
    // a start condition already present at release still starts a conversion once it is through the flops
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_reg            <= '0;
            state_reg.phase      <= aorc_pkg::PH_IDLE;
            state_reg.drive      <= aorc_pkg::DRV_OFF;
            state_reg.oe_n       <= aorc_pkg::OE_N_OFF;
            state_reg.status     <= aorc_pkg::STATUS_RST;
            state_reg.mask       <= aorc_pkg::MASK_RST;
            state_reg.start_prev <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // every output comes straight from the state register
    assign DAC_CODE  = state_reg.trial;
    assign DATA_OUT  = state_reg.data;
    assign DATA_OE_N = state_reg.oe_n;
    assign CONV_BUSY = state_reg.busy;
    assign REG_RDATA = state_reg.rdata;
    assign IRQ       = state_reg.irq;

endmodule : aorc_top

// [tb/aorc_checker.sv]
// port-level assertions for the converter output-read block
`timescale 1ns/10ps
module aorc_checker #(
    parameter int unsigned BIT_CYC = 4
) (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        READ_CONVERT,
    input wire logic        CHIP_ENABLE,
    input wire logic        CHIP_SELECT_N,
    input wire logic        BYTE_SELECT,
    input wire logic        WORD_WIDTH_SELECT,
    input wire logic [11:0] DATA_OUT,
    input wire logic [11:0] DATA_OE_N,
    input wire logic        CONV_BUSY,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA
);
    logic [7:0] busy_cnt_reg;
    logic       no_read;
    assign no_read = !READ_CONVERT || !CHIP_ENABLE || CHIP_SELECT_N;
    // length of the current busy period in cycles
    always_ff @(posedge CLK) begin
        if (SYS_RST || !CONV_BUSY)
            busy_cnt_reg <= 8'h00;
        else
            busy_cnt_reg <= busy_cnt_reg + 8'h01;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    a_busy_floats: assert property (CONV_BUSY |-> DATA_OE_N == aorc_pkg::OE_N_OFF)
        else $error("outputs driven while busy");
    a_idle_floats: assert property (no_read [*4] |=> DATA_OE_N == aorc_pkg::OE_N_OFF)
        else $error("outputs driven without all read conditions");
    a_legal_pattern: assert property (DATA_OE_N inside {12'hFFF, 12'h000, 12'h00F, 12'hF00})
        else $error("illegal output enable pattern");
    a_break_high: assert property (DATA_OE_N == aorc_pkg::OE_N_HIGH |=> DATA_OE_N != 12'hF00)
        else $error("low nibble enabled straight after high byte");
    a_break_low: assert property (DATA_OE_N == aorc_pkg::OE_N_LOW |=> DATA_OE_N != 12'h00F)
        else $error("high byte enabled straight after low nibble");
    a_nibble_zero: assert property (DATA_OE_N == 12'hF00 |-> DATA_OUT[7:4] == 4'h0)
        else $error("bits 7 to 4 not zero in low nibble read");
    a_word_mode: assert property ((WORD_WIDTH_SELECT [*4] ##1 DATA_OE_N != 12'hFFF)
        |-> DATA_OE_N == 12'h000)
        else $error("word read did not enable all twelve bits");
    a_high_byte: assert property (((!WORD_WIDTH_SELECT && !BYTE_SELECT) [*4]
        ##1 DATA_OE_N != 12'hFFF) |-> DATA_OE_N == 12'h00F)
        else $error("high byte read enabled wrong bits");
    a_low_nibble: assert property (((!WORD_WIDTH_SELECT && BYTE_SELECT) [*4]
        ##1 DATA_OE_N != 12'hFFF) |-> DATA_OE_N == 12'hF00)
        else $error("low nibble read enabled wrong bits");
    a_busy_length: assert property ($fell(CONV_BUSY) |-> busy_cnt_reg == 12 * BIT_CYC + 15
        || busy_cnt_reg == 8 * BIT_CYC + 15)
        else $error("busy period has wrong length");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data outside read cycle");
endmodule : aorc_checker
bind aorc_top aorc_checker #(.BIT_CYC(BIT_CYC)) chk_u (.CLK(CLK), .SYS_RST(SYS_RST),
    .READ_CONVERT(READ_CONVERT), .CHIP_ENABLE(CHIP_ENABLE), .CHIP_SELECT_N(CHIP_SELECT_N),
    .BYTE_SELECT(BYTE_SELECT), .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT), .DATA_OUT(DATA_OUT),
    .DATA_OE_N(DATA_OE_N), .CONV_BUSY(CONV_BUSY), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

// [tb/aorc_front_end.sv]
// comparator model of the analog front end
`timescale 1ns/10ps
module aorc_front_end (
    input  wire logic [11:0] DAC_CODE,
    input  wire logic [11:0] LEVEL,
    output logic             COMP_IN
);
    // input sits half a step above the level code, so an ideal search returns the level
    assign COMP_IN = {LEVEL, 1'b1} > {DAC_CODE, 1'b0};
endmodule : aorc_front_end

// [tb/test_adc_output_read_control.sv]
// self-checking testbench of the converter output-read block
`timescale 1ns/10ps
module test_adc_output_read_control;
    logic        clk, sys_rst, rc, ce, cs_n, bs, wws, comp, busy, reg_wr, reg_rd, irq, sh;
    logic [11:0] dac, dout, oe_n, level, exp_res;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    int          fail_count, checked;

    aorc_top #(.BIT_CYC(4)) dut_u (.CLK(clk), .SYS_RST(sys_rst), .READ_CONVERT(rc),
        .CHIP_ENABLE(ce), .CHIP_SELECT_N(cs_n), .BYTE_SELECT(bs), .WORD_WIDTH_SELECT(wws),
        .COMP_IN(comp), .DAC_CODE(dac), .DATA_OUT(dout), .DATA_OE_N(oe_n), .CONV_BUSY(busy),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(rdata), .IRQ(irq));
    aorc_front_end front_u (.DAC_CODE(dac), .LEVEL(level), .COMP_IN(comp));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [31:0] e, input string what);
        @(posedge clk);
        addr   <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(what, e, rdata);
    endtask : reg_check

    function automatic logic [11:0] expect_result(input logic [11:0] lv, input logic s);
        return s ? {lv[11:4], aorc_pkg::SHORT_FILL} : lv;
    endfunction : expect_result

    // start with all three conditions set in one cycle, optionally retrigger while busy
    task automatic convert(input logic retrig);
        int n;
        @(posedge clk);
        bs   <= sh;
        wws  <= 1'($urandom_range(1, 0));
        ce   <= 1'b1;
        cs_n <= 1'b0;
        rc   <= 1'b0;
        repeat (4) @(posedge clk);
        rc <= 1'b1;
        settle(8);
        check("busy after start", 1, busy);
        if (retrig) begin
            @(posedge clk);
            rc <= 1'b0;
            bs <= !sh;
            repeat (4) @(posedge clk);
            rc <= 1'b1;
        end
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            settle(0);
            n++;
        end
        check("busy fall", 0, busy);
    endtask : convert

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial begin
        void'($urandom(32'h419ebefa));
        {sys_rst, rc, cs_n, wws} = 4'hF;
        {ce, bs, reg_wr, reg_rd, addr, wdata, level} = '0;
        fail_count = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        settle(2);
        check("enable after reset", 12'hFFF, oe_n);
        reg_check(aorc_pkg::STATUS_OFS, 32'h0, "status reset");
        reg_check(aorc_pkg::MASK_OFS, 32'h0, "mask reset");
        reg_write(8'h10, 32'h3);
        reg_check(8'h10, 32'h0, "unmapped read");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            level <= (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($urandom);
            sh = 1'(i % 2);
            reg_write(aorc_pkg::MASK_OFS, {31'h0, i != 3});
            convert(i == 2);
            settle(3);
            check("irq raised", {31'h0, i != 3}, irq);
            reg_check(aorc_pkg::STATUS_OFS, {30'h0, i == 2, 1'b1}, "status");
            reg_write(aorc_pkg::STATUS_OFS, 32'h3);
            settle(2);
            check("irq cleared", 0, irq);
            exp_res = expect_result(level, sh ^ (i == 2));
            reg_check(aorc_pkg::RESULT_OFS, {20'h0, exp_res}, "result reg");
            @(posedge clk);
            wws <= 1'b1;
            settle(5);
            check("word enable", 12'h000, oe_n);
            check("word data", exp_res, dout);
            @(posedge clk);
            wws <= 1'b0;
            bs  <= 1'b0;
            settle(5);
            check("high byte enable", 12'h00F, oe_n);
            check("high byte data", exp_res[11:4], dout[11:4]);
            @(posedge clk);
            bs <= 1'b1;
            settle(5);
            check("low nibble enable", 12'hF00, oe_n);
            check("low nibble data", {4'h0, exp_res[3:0]}, dout[7:0]);
            reg_check(aorc_pkg::CTRL_OFS, {28'h0, sh ^ (i == 2), 3'h3}, "ctrl");
            repeat (12) begin
                @(posedge clk);
                bs <= 1'($urandom);
            end
            ce <= 1'b0;
            settle(4);
            check("float after enable drop", 12'hFFF, oe_n);
        end
        close_out();
    end
endmodule : test_adc_output_read_control
